// ---- hdl/wdog_cfg.svh ----
// Register map, field positions, reset values and timing counts of the watchdog control block.
// How it works
// [RQ1] The counter advances only while the timer enable bit is set, and setting it resumes without clearing the count.
// [RQ2] While the debug pause bit is set the counter holds and no expiry action is taken.
// [RQ3] The restart source bit selects hardware-only or software-only restart; the software restart bit restarts only under software-only.
// [RQ4] In SLEEP the timer stays stopped unless the sleep run enable bit is set, in which case it follows the enable bit.
// [RQ5] After one period without restart the primary action runs: 00 none, 01 interrupt, 10 device reset, 11 WAKE; default 01.
// [RQ6] After two periods without restart the secondary action runs with the same coding; default 10.
// [RQ7] A three-bit code selects a period from 0.256 s at 000, doubling per step, to 32.768 s at 111, the default.
// [RQ8] The protected fields of the control register change only while the security key has unlocked them.
// [RQ9] A restart clears the elapsed count so both actions are timed again from the restart.
`ifndef WDOG_CFG_SVH
`define WDOG_CFG_SVH

`define WDOG_ADDR_W          16
`define WDOG_CTRL_ADDR       16'h4004
`define WDOG_IRQ_STAT_ADDR   16'h4020
`define WDOG_IRQ_CLR_ADDR    16'h4021
`define WDOG_IRQ_EN_ADDR     16'h4022

`define WDOG_BIT_ENABLE      15
`define WDOG_BIT_PAUSE       14
`define WDOG_BIT_SRC         13
`define WDOG_BIT_SLEEP       12
`define WDOG_BIT_SWRESTART   11
`define WDOG_SEC_HI          9
`define WDOG_SEC_LO          8
`define WDOG_PRIM_HI         5
`define WDOG_PRIM_LO         4
`define WDOG_PER_HI          2
`define WDOG_PER_LO          0

`define WDOG_RST_ENABLE      1'b1
`define WDOG_RST_PAUSE       1'b0
`define RESTART_SOURCE_SELECT         1'b1
`define WDOG_RST_SLEEP       1'b0
`define WDOG_RST_SEC         2'h2
`define WDOG_RST_PRIM        2'h1
`define WDOG_RST_PER         3'h7

// Base period is 0.256 s; at 125 MHz that is 32,000,000 cycles.
`define WDOG_BASE_PERIOD_MS  256
`define WDOG_CLK_KHZ         125000
`define WDOG_BASE_CYCLES     (`WDOG_BASE_PERIOD_MS * `WDOG_CLK_KHZ)

`endif

// ---- hdl/wdog_pkg.sv ----
// Types shared by the watchdog control block.
package wdog_pkg;

  typedef enum logic [1:0] {
    ACT_NONE  = 2'b00,
    ACT_IRQ   = 2'b01,
    ACT_RESET = 2'b10,
    ACT_WAKE  = 2'b11
  } action_t;

  typedef enum logic [1:0] {
    PH_FIRST  = 2'b00,
    PH_SECOND = 2'b01,
    PH_DONE   = 2'b10
  } phase_t;

endpackage

// ---- hdl/wdog_action_decode.sv ----
// Turns an expiry action code into one-cycle action pulses.
`timescale 1ns/1ps
`default_nettype none
module wdog_action_decode (
  // Trigger and selected action
  input  wire logic            fire,
  input  wire wdog_pkg::action_t action,
  // Action pulses
  output logic                 irqPulse,
  output logic                 resetPulse,
  output logic                 wakePulse
);
  always_comb begin
    irqPulse   = fire && (action == wdog_pkg::ACT_IRQ);
    resetPulse = fire && (action == wdog_pkg::ACT_RESET);
    wakePulse  = fire && (action == wdog_pkg::ACT_WAKE);
  end
endmodule
`default_nettype wire

// ---- hdl/wdog_prescaler.sv ----
// Base tick generator: one pulse per base period of the timeout scale.
`timescale 1ns/1ps
`default_nettype none
module wdog_prescaler #(
  parameter int unsigned BASE_CYCLES = 32000000
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst,
  // Control
  input  wire logic run,
  input  wire logic clear,
  // Tick out
  output logic      tick
);
  typedef struct packed {
    logic [31:0] count;
    logic        tick;
  } state_t;

  state_t s_reg;
  state_t s_next;

  if (BASE_CYCLES < 2) begin
    $error("wdog_prescaler: BASE_CYCLES must be at least 2");
  end

  always_comb begin
    s_next      = s_reg;
    s_next.tick = 1'b0;
    if (clear) begin
      s_next.count = 32'h0;
    end else if (run) begin
      if (s_reg.count == BASE_CYCLES - 1) begin
        s_next.count = 32'h0;
        s_next.tick  = 1'b1;
      end else begin
        s_next.count = s_reg.count + 32'h1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign tick = s_reg.tick;
endmodule
`default_nettype wire

// ---- hdl/wdog_control.sv ----
// Watchdog timer with its control register, expiry actions and interrupt registers.
`timescale 1ns/1ps
`default_nettype none
`include "wdog_cfg.svh"
module wdog_control #(
  parameter int unsigned BASE_CYCLES = `WDOG_BASE_CYCLES
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // Register port
  input  wire logic [15:0] regAddr,
  input  wire logic [15:0] regWdata,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [15:0] regRdata,
  // Device state inputs
  input  wire logic        keyUnlocked,
  input  wire logic        sleepState,
  input  wire logic        hwKick,
  // Actions
  output logic             deviceResetReq,
  output logic             wakeReq,
  output logic             irq
);
  typedef struct packed {
    logic        enable;
    logic        pause;
    logic        srcSoftware;
    logic        sleepRun;
    logic [1:0]  secAction;
    logic [1:0]  primAction;
    logic [2:0]  period;
    logic [7:0]  ticks;
    wdog_pkg::phase_t phase;
    logic [1:0]  kickSync;
    logic        kickPrev;
    logic        unlockSync0;
    logic        unlockSync1;
    logic        sleepSync0;
    logic        sleepSync1;
    logic [1:0]  irqStatus;
    logic [1:0]  irqEnable;
    logic        resetOut;
    logic        wakeOut;
    logic [15:0] rdata;
  } state_t;

  state_t s_reg;
  state_t s_next;

  logic tick;
  logic running;
  logic restart;
  logic primFire;
  logic secFire;
  logic primIrq;
  logic primRst;
  logic primWake;
  logic secIrq;
  logic secRst;
  logic secWake;
  logic [7:0] periodTicks;
  logic ctrlWrite;

  if (BASE_CYCLES < 2) begin
    $error("wdog_control: BASE_CYCLES must be at least 2");
  end

  function automatic logic [7:0] ticks_for(input logic [2:0] code);
    ticks_for = 8'h1 << code;
  endfunction

  function automatic logic [15:0] ctrl_image(input state_t s);
    logic [15:0] v;
    v = 16'h0;
    v[`WDOG_BIT_ENABLE] = s.enable;
    v[`WDOG_BIT_PAUSE]  = s.pause;
    v[`WDOG_BIT_SRC]    = s.srcSoftware;
    v[`WDOG_BIT_SLEEP]  = s.sleepRun;
    v[`WDOG_SEC_HI:`WDOG_SEC_LO]   = s.secAction;
    v[`WDOG_PRIM_HI:`WDOG_PRIM_LO] = s.primAction;
    v[`WDOG_PER_HI:`WDOG_PER_LO]   = s.period;
    ctrl_image = v;
  endfunction

  assign ctrlWrite   = regWrite && (regAddr == `WDOG_CTRL_ADDR);
  assign periodTicks = ticks_for(s_reg.period); // RQ7
  // SLEEP stops the timer unless sleep running is allowed, then the enable bit rules.
  assign running = s_reg.enable && !s_reg.pause && (!s_reg.sleepSync1 || s_reg.sleepRun); // RQ1 RQ2 RQ4
  // Software restart counts only under software-only source; the pin only under hardware-only.
  assign restart = s_reg.srcSoftware
                 ? (ctrlWrite && regWdata[`WDOG_BIT_SWRESTART])
                 : (s_reg.kickSync[1] && !s_reg.kickPrev); // RQ3
  // A shorter period written once the count has reached its new end expires at the next tick instead of after a wrap.
  assign primFire = running && tick && s_reg.phase == wdog_pkg::PH_FIRST
                  && s_reg.ticks >= periodTicks - 8'h1; // RQ5
  assign secFire  = running && tick && s_reg.phase == wdog_pkg::PH_SECOND
                  && s_reg.ticks >= periodTicks - 8'h1; // RQ6

  wdog_prescaler #(
    .BASE_CYCLES (BASE_CYCLES)
  ) u_prescaler (
    .clock (clock),
    .rst   (rst),
    .run   (running),
    .clear (restart),
    .tick  (tick)
  );

  wdog_action_decode u_prim (
    .fire       (primFire),
    .action     (wdog_pkg::action_t'(s_reg.primAction)),
    .irqPulse   (primIrq),
    .resetPulse (primRst),
    .wakePulse  (primWake)
  );

  wdog_action_decode u_sec (
    .fire       (secFire),
    .action     (wdog_pkg::action_t'(s_reg.secAction)),
    .irqPulse   (secIrq),
    .resetPulse (secRst),
    .wakePulse  (secWake)
  );

  always_comb begin
    s_next = s_reg;
    // Pin-side levels pass two flops before use.
    s_next.kickSync    = {s_reg.kickSync[0], hwKick};
    s_next.kickPrev    = s_reg.kickSync[1];
    s_next.unlockSync0 = keyUnlocked;
    s_next.unlockSync1 = s_reg.unlockSync0;
    s_next.sleepSync0  = sleepState;
    s_next.sleepSync1  = s_reg.sleepSync0;
    s_next.resetOut    = primRst || secRst;
    s_next.wakeOut     = primWake || secWake;

    if (ctrlWrite && s_reg.unlockSync1) begin
      s_next.enable      = regWdata[`WDOG_BIT_ENABLE]; // RQ8 RQ1
      s_next.pause       = regWdata[`WDOG_BIT_PAUSE]; // RQ8
      s_next.srcSoftware = regWdata[`WDOG_BIT_SRC]; // RQ8
      s_next.sleepRun    = regWdata[`WDOG_BIT_SLEEP]; // RQ8
      s_next.secAction   = regWdata[`WDOG_SEC_HI:`WDOG_SEC_LO]; // RQ8
      s_next.primAction  = regWdata[`WDOG_PRIM_HI:`WDOG_PRIM_LO]; // RQ8
      s_next.period      = regWdata[`WDOG_PER_HI:`WDOG_PER_LO]; // RQ8
    end
    if (regWrite && regAddr == `WDOG_IRQ_EN_ADDR) begin
      s_next.irqEnable = regWdata[1:0];
    end
    if (regWrite && regAddr == `WDOG_IRQ_CLR_ADDR) begin
      s_next.irqStatus = s_reg.irqStatus & ~regWdata[1:0];
    end
    // Setting wins over a clear in the same cycle.
    s_next.irqStatus[0] = s_next.irqStatus[0] | primIrq; // RQ5
    s_next.irqStatus[1] = s_next.irqStatus[1] | secIrq; // RQ6

    if (restart) begin
      s_next.ticks = 8'h0; // RQ9
      s_next.phase = wdog_pkg::PH_FIRST; // RQ9
    end else if (running && tick) begin // RQ2
      case (s_reg.phase)
        wdog_pkg::PH_FIRST: begin
          if (primFire) begin
            s_next.ticks = 8'h0;
            s_next.phase = wdog_pkg::PH_SECOND;
          end else begin
            s_next.ticks = s_reg.ticks + 8'h1;
          end
        end
        wdog_pkg::PH_SECOND: begin
          if (secFire) begin
            s_next.ticks = 8'h0;
            s_next.phase = wdog_pkg::PH_DONE;
          end else begin
            s_next.ticks = s_reg.ticks + 8'h1;
          end
        end
        wdog_pkg::PH_DONE: begin
          s_next.ticks = s_reg.ticks;
        end
        default: begin
          s_next.phase = wdog_pkg::PH_FIRST;
        end
      endcase
    end

    s_next.rdata = 16'h0;
    if (regRead) begin
      case (regAddr)
        `WDOG_CTRL_ADDR:     s_next.rdata = ctrl_image(s_reg);
        `WDOG_IRQ_STAT_ADDR: s_next.rdata = {14'h0, s_reg.irqStatus};
        `WDOG_IRQ_EN_ADDR:   s_next.rdata = {14'h0, s_reg.irqEnable};
        default:             s_next.rdata = 16'h0;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_reg             <= '0;
      s_reg.enable      <= `WDOG_RST_ENABLE;
      s_reg.pause       <= `WDOG_RST_PAUSE;
      s_reg.srcSoftware <= `RESTART_SOURCE_SELECT;
      s_reg.sleepRun    <= `WDOG_RST_SLEEP;
      s_reg.secAction   <= `WDOG_RST_SEC;
      s_reg.primAction  <= `WDOG_RST_PRIM;
      s_reg.period      <= `WDOG_RST_PER;
      s_reg.phase       <= wdog_pkg::PH_FIRST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign regRdata       = s_reg.rdata;
  assign deviceResetReq = s_reg.resetOut;
  assign wakeReq        = s_reg.wakeOut;
  assign irq            = |(s_reg.irqStatus & s_reg.irqEnable);
endmodule
`default_nettype wire

// ---- sim/wdog_host.sv ----
// Host model: holds the security key and drives the hardware restart line.
`timescale 1ns/1ps
`default_nettype none
module wdog_host (
  // Clock
  input  wire logic clock,
  // Commands from the bench
  input  wire logic unlock,
  input  wire logic kick,
  // Device side
  output logic      keyUnlocked,
  output logic      hwKick
);
  logic [2:0] phase;
  initial begin
    phase = 3'h0;
    keyUnlocked = 1'b0;
    hwKick = 1'b0;
  end
  // The key is only lifted when the bench asks, so locked writes can be tried first.
  always @(posedge clock) begin
    keyUnlocked <= unlock;
    phase <= kick ? phase + 3'h1 : 3'h0;
    hwKick <= kick && phase[2];
  end
endmodule
`default_nettype wire

// ---- sim/wdog_control_props.sv ----
// Port-level assertions for the watchdog control block.
`timescale 1ns/1ps
`default_nettype none
module wdog_control_props #(
  parameter int unsigned BASE_CYCLES = 32000000
) (
  // Clock and reset
  input wire logic        clock,
  input wire logic        rst,
  // Register port
  input wire logic [15:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic        regWrite,
  input wire logic        regRead,
  input wire logic [15:0] regRdata,
  // Device state and actions
  input wire logic        keyUnlocked,
  input wire logic        sleepState,
  input wire logic        hwKick,
  input wire logic        deviceResetReq,
  input wire logic        wakeReq,
  input wire logic        irq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  logic mapped;
  assign mapped = regAddr == 16'h4004 || (regAddr >= 16'h4020 && regAddr <= 16'h4022);
  sequence ctrlRead;
    regRead && regAddr == 16'h4004;
  endsequence
  sequence lockedWrite;
    (ctrlRead and !keyUnlocked) ##1 (!keyUnlocked && !regWrite)
      ##1 (regWrite && regAddr == 16'h4004 && !keyUnlocked) ##2 ctrlRead;
  endsequence
  rdata_idle_a: assert property (!$past(regRead) |-> regRdata == 16'h0000)
    else $error("read data outside its cycle");
  unmapped_read_a: assert property (regRead && !mapped |=> regRdata == 16'h0000)
    else $error("unmapped read not zero");
  restart_bit_a: assert property (ctrlRead |=> !regRdata[11])
    else $error("restart bit reads back set");
  locked_write_a: assert property (lockedWrite |=> regRdata == $past(regRdata, 4))
    else $error("locked control write took effect");
  reset_pulse_a: assert property (deviceResetReq |=> !deviceResetReq [*3])
    else $error("reset request too long or too close");
  wake_pulse_a: assert property (wakeReq |=> !wakeReq [*3])
    else $error("wake request too long or too close");
  one_action_a: assert property (!(deviceResetReq && wakeReq))
    else $error("two actions at once");
  irq_mask_a: assert property (regWrite && regAddr == 16'h4022 && regWdata[1:0] == 2'h0
    |=> !irq)
    else $error("masked interrupt still high");
endmodule
bind wdog_control wdog_control_props #(.BASE_CYCLES(BASE_CYCLES)) u_props (
  .clock(clock), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
  .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
  .keyUnlocked(keyUnlocked), .sleepState(sleepState), .hwKick(hwKick),
  .deviceResetReq(deviceResetReq), .wakeReq(wakeReq), .irq(irq));
`default_nettype wire

// ---- sim/wdog_control_tb.sv ----
// Self-checking bench for the watchdog control block.
`timescale 1ns/1ps
`default_nettype none
module wdog_control_tb;
  localparam logic [15:0] CTRL = 16'h4004;
  localparam logic [15:0] STAT = 16'h4020;
  localparam logic [15:0] CLR = 16'h4021;
  localparam logic [15:0] EN = 16'h4022;
  logic        clock, rst, regWrite, regRead, sleepState, unlock, kick;
  logic [15:0] regAddr, regWdata, regRdata;
  logic        keyUnlocked, hwKick, deviceResetReq, wakeReq, irq;
  logic [15:0] stops [4] = '{16'he011, 16'h2011, 16'ha011, 16'hb011};
  int          numErrors, numChecks, nRst, nWake, t0, n;
  wdog_host u_host (.clock(clock), .unlock(unlock), .kick(kick),
    .keyUnlocked(keyUnlocked), .hwKick(hwKick));
  wdog_control #(.BASE_CYCLES(4)) u_dut (.clock(clock), .rst(rst), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .keyUnlocked(keyUnlocked), .sleepState(sleepState), .hwKick(hwKick),
    .deviceResetReq(deviceResetReq), .wakeReq(wakeReq), .irq(irq));
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // Counting starts only once reset has defined the pulse outputs.
  always @(posedge clock) begin
    if (rst) begin
      nRst <= 0;
      nWake <= 0;
    end else begin
      nRst <= nRst + deviceResetReq;
      nWake <= nWake + wakeReq;
    end
  end
  task automatic results;
    if (numErrors == 0 && numChecks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    numChecks++;
    if (seen !== exp) begin
      numErrors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clock);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    #1 chk(regRdata, exp);
  endtask
  // A hang here would stall the run, so the wait is capped and ends it.
  task automatic waitIrq(input int lim, output int cyc);
    cyc = 0;
    while (irq !== 1'b1 && cyc < lim) begin
      @(posedge clock);
      #1 cyc++;
    end
    if (cyc >= lim) begin
      numErrors++;
      results();
    end
  endtask
  // Stop, clear status, then restart from zero with the given setting.
  task automatic arm(input logic [15:0] c);
    wr(CTRL, 16'h2000);
    wr(CLR, 16'h0003);
    wr(CTRL, c | 16'h0800);
  endtask
  initial begin
    {rst, regWrite, regRead, sleepState, unlock, kick} = 6'b100000;
    regAddr = 16'h0000;
    regWdata = 16'h0000;
    {numErrors, numChecks} = '0;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    rd(CTRL, 16'ha217);
    wr(CTRL, 16'h0000);
    rd(CTRL, 16'ha217);
    rd(16'h4010, 16'h0000);
    unlock <= 1'b1;
    wr(EN, 16'h0003);
    for (int c = 0; c < 4; c++) begin
      t0 = nRst;
      n = nWake;
      arm(16'ha000 | (16'(c) << 8) | (16'(c) << 4));
      repeat (40) @(posedge clock);
      chk(16'(nRst - t0), (c == 2) ? 16'h0002 : 16'h0000);
      chk(16'(nWake - n), (c == 3) ? 16'h0002 : 16'h0000);
      rd(STAT, (c == 1) ? 16'h0003 : 16'h0000);
    end
    arm(16'ha010);
    repeat (20) @(posedge clock);
    chk(16'(irq), 16'h0001);
    wr(EN, 16'h0000);
    chk(16'(irq), 16'h0000);
    wr(EN, 16'h0003);
    chk(16'(irq), 16'h0001);
    wr(CLR, 16'h0003);
    chk(16'(irq), 16'h0000);
    for (int c = 0; c < 4; c++) begin
      arm(16'ha010 | 16'(c));
      waitIrq(600, n);
      if (c == 0) t0 = n;
      chk(16'(n - t0), 16'(4 * ((1 << c) - 1)));
    end
    for (int s = 0; s < 4; s++) begin
      sleepState <= s >= 2;
      arm(16'ha011);
      wr(CTRL, stops[s]);
      repeat (40) @(posedge clock);
      chk(16'(irq), 16'(s == 3));
      sleepState <= 1'b0;
      wr(CTRL, 16'ha011);
      waitIrq(20, n);
      // Pause or disable struck two counted cycles in, so the resumed count ends sooner.
      if (s < 3) chk(16'(n), (s == 2) ? 16'h0009 : 16'h0007);
    end
    arm(16'ha012);
    wr(CTRL, 16'h8012);
    kick <= 1'b1;
    repeat (80) @(posedge clock);
    chk(16'(irq), 16'h0000);
    kick <= 1'b0;
    // The last kick restart expires before these writes end, unless a write restarted it.
    for (int i = 0; i < 12; i++) wr(CTRL, 16'h8812);
    chk(16'(irq), 16'h0001);
    waitIrq(30, n);
    results();
  end
endmodule
`default_nettype wire
